// ---- design/lp3i_cfg_mem.sv ----
// Small store for the write-only mode registers.
// Assumes one write and one read per cycle; read data registered.
`timescale 1ns/1ps
module lp3i_cfg_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  // No reset: contents read back as undefined until written
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : lp3i_cfg_mem

// ---- design/lp3i_init_seq.sv ----
// Power-up, reset and initialization sequencer with the mode register map.
// Assumes decoded commands, clock enable and self-test strap arrive as pins.
`timescale 1ns/1ps
module lp3i_init_seq
  import lp3i_pkg::*;
#(
  // Reset wait plus auto-init must fit inside the maximum time
  parameter int         AUTO_INIT_CYC    = AUTO_INIT_MAX_CYC - POST_RESET_IDLE_CYC,
  parameter logic       RL3_SUPPORT      = 1'b1,
  parameter logic       ALT_WL_SUPPORT   = 1'b1,
  parameter logic [2:0] REFRESH_RATE     = 3'h3,
  parameter logic [7:0] MAKER_ID         = 8'hA5, // Arbitrary value
  parameter logic [7:0] REVISION_ONE     = 8'h11, // Arbitrary value
  parameter logic [7:0] REVISION_TWO     = 8'h22, // Arbitrary value
  parameter logic [7:0] WIDTH_DENSITY    = 8'h1F,
  parameter logic [7:0] CALIB_PATTERN_A  = 8'h55,
  parameter logic [7:0] CALIB_PATTERN_B  = 8'h33
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 cke_pin,
  input  wire lp3i_pkg::lp3i_cmd_t  cmd_pin,
  input  wire logic [1:0]           zq_strap,
  output logic      [7:0]           rd_data,
  output logic                      rd_valid,
  output logic                      dqs_strobe,
  output logic                      dq_oe,
  output logic                      dev_ready,
  output logic                      auto_init_pending,
  output logic                      cmd_refused
);
  import lp3i_pkg::*;

  localparam int SW = $bits(lp3i_cmd_t) + 3;

  lp3i_cmd_t   cmd_s;
  logic        cke_s;
  logic [1:0]  zq_s;
  lp3i_state_t state;
  logic [TMR_W-1:0] timer;
  logic        is_rst;
  logic        acc_mrr;
  logic        acc_mrw;
  logic        acc_pd;
  logic        acc_other;
  logic        mem_wr;
  logic        cal_start;
  logic        pd_active;
  logic [1:0]  zq_result;
  logic        rd_pend;
  logic [7:0]  rd_addr_q;
  logic [7:0]  mem_rdata;
  logic [7:0]  dev_info;

  // All pin inputs cross into the core clock
  lp3i_sync #(
    .WIDTH (SW)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    ({cke_pin, zq_strap, cmd_pin}),
    .dout   ({cke_s, zq_s, cmd_s})
  );

  // Command acceptance per sequence step
  always_comb
  begin
    is_rst    = cmd_s.valid && cke_s && state != ST_OFF &&
                cmd_s.op == CMD_MRW &&
                cmd_s.addr == MA_DEVICE_RESET_TRIGGER; // R13 R20
    acc_mrr   = 1'b0;
    acc_mrw   = 1'b0;
    acc_pd    = 1'b0;
    acc_other = 1'b0;
    if (cmd_s.valid && cke_s && !is_rst)
    begin
      case (state)
        ST_CKE_IDLE:
        begin
          acc_other = cmd_s.op == CMD_PREA;
        end
        ST_AUTO_INIT, ST_IMPEDANCE_CALIBRATION_COMMAND:
        begin
          acc_mrr = cmd_s.op == CMD_MRR; // R4
          acc_pd  = cmd_s.op == CMD_PDE || cmd_s.op == CMD_PDX; // R4
        end
        ST_PRE_CAL, ST_READY:
        begin
          acc_mrr   = cmd_s.op == CMD_MRR;
          acc_pd    = cmd_s.op == CMD_PDE || cmd_s.op == CMD_PDX;
          acc_mrw   = cmd_s.op == CMD_MRW;
          acc_other = state == ST_READY && cmd_s.op == CMD_PREA;
        end
        default:
        begin
          acc_other = 1'b0;
        end
      endcase
    end
  end

  // Writes to read-only or reserved addresses are dropped
  assign mem_wr    = acc_mrw && is_wo(cmd_s.addr); // R19
  // Only the initial code in the pre-calibration step starts calibration
  assign cal_start = acc_mrw && state == ST_PRE_CAL &&
                     cmd_s.addr == MA_IMPEDANCE_CAL_CMD &&
                     cmd_s.data == CAL_CODE_INIT; // R20 R24

  // Sequence state and step timer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_OFF;
      timer <= '0;
    end
    else if (is_rst)
    begin
      state <= ST_RST_WAIT; // R13
      timer <= '0;
    end
    else
    begin
      case (state)
        ST_OFF:
        begin
          if (cke_s)
          begin
            state <= ST_CKE_IDLE;
          end
        end
        ST_RST_WAIT:
        begin
          if (timer == TMR_W'(POST_RESET_IDLE_CYC - 1))
          begin
            state <= ST_AUTO_INIT;
            timer <= '0;
          end
          else
          begin
            timer <= timer + 1'b1;
          end
        end
        ST_AUTO_INIT:
        begin
          // Completes on its own, polled or not
          if (timer == TMR_W'(AUTO_INIT_CYC - 1)) // R7
          begin
            state <= ST_PRE_CAL;
            timer <= '0;
          end
          else
          begin
            timer <= timer + 1'b1;
          end
        end
        ST_PRE_CAL:
        begin
          if (cal_start)
          begin
            state <= ST_IMPEDANCE_CALIBRATION_COMMAND;
            timer <= '0;
          end
        end
        ST_IMPEDANCE_CALIBRATION_COMMAND:
        begin
          if (timer == TMR_W'(INIT_IMPEDANCE_CAL_CYC - 1)) // R11
          begin
            state <= ST_READY;
            timer <= '0;
          end
          else
          begin
            timer <= timer + 1'b1;
          end
        end
        default:
        begin
          timer <= '0;
        end
      endcase
    end
  end

  // Pending flag: busy from reset command until auto-init ends
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      auto_init_pending <= 1'b1;
    end
    else if (is_rst)
    begin
      auto_init_pending <= 1'b1; // R6
    end
    else if (state == ST_AUTO_INIT && timer == TMR_W'(AUTO_INIT_CYC - 1))
    begin
      auto_init_pending <= 1'b0; // R6
    end
  end

  // Ready and self-test result appear when calibration time has passed
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dev_ready <= 1'b0;
      zq_result <= ZQ_RESULT_RESET;
    end
    else if (is_rst)
    begin
      dev_ready <= 1'b0;
      zq_result <= ZQ_RESULT_RESET;
    end
    else if (state == ST_IMPEDANCE_CALIBRATION_COMMAND &&
             timer == TMR_W'(INIT_IMPEDANCE_CAL_CYC - 1))
    begin
      dev_ready <= 1'b1; // R11
      zq_result <= zq_s; // R21
    end
  end

  // Power-down tracking; a reset command also leaves power-down
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pd_active <= 1'b0;
    end
    else if (is_rst || (acc_pd && cmd_s.op == CMD_PDX))
    begin
      pd_active <= 1'b0;
    end
    else if (acc_pd)
    begin
      pd_active <= 1'b1;
    end
  end

  // Drivers stay off while clock enable is low or powered down
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dq_oe <= 1'b0;
    end
    else
    begin
      dq_oe <= cke_s && !pd_active && state != ST_OFF; // R16
    end
  end

  // Any command given with clock enable high that is not a no-operation and not taken is refused
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_refused <= 1'b0;
    end
    else
    begin
      cmd_refused <= cmd_s.valid && cke_s && cmd_s.op != CMD_NOP &&
                     !(is_rst || acc_mrr || acc_mrw || acc_pd || acc_other);
    end
  end

  lp3i_cfg_mem #(
    .AW (6),
    .DW (8)
  ) u_cfg_mem (
    .clk     (clk),
    .wr_en   (mem_wr),
    .wr_addr (cmd_s.addr[5:0]),
    .wr_data (cmd_s.data),
    .rd_en   (acc_mrr),
    .rd_addr (cmd_s.addr[5:0]),
    .rd_data (mem_rdata)
  );

  // Reserved bits of the status register read as zero
  assign dev_info = {RL3_SUPPORT, ALT_WL_SUPPORT, 1'b0, zq_result,
                     2'b00, auto_init_pending}; // R6 R17 R22

  // Read request stage; store read lines up one cycle later
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_pend   <= 1'b0;
      rd_addr_q <= 8'h00;
    end
    else
    begin
      rd_pend   <= acc_mrr;
      rd_addr_q <= acc_mrr ? cmd_s.addr : rd_addr_q;
    end
  end

  // Answer stage: every read strobes, whatever the address
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_valid   <= 1'b0;
      rd_data    <= RD_DATA_RESET;
      dqs_strobe <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_pend;
      if (rd_pend)
      begin
        dqs_strobe <= !dqs_strobe; // R18
        case (rd_addr_q)
          MA_DEVICE_INFO_STATUS:  rd_data <= dev_info;
          MA_REFRESH_RATE_STATUS: rd_data <= {5'h00, REFRESH_RATE};
          MA_MAKER_CODE:          rd_data <= MAKER_ID;
          MA_REVISION_CODE_ONE:   rd_data <= REVISION_ONE;
          MA_REVISION_CODE_TWO:   rd_data <= REVISION_TWO;
          MA_WIDTH_DENSITY_TYPE:  rd_data <= WIDTH_DENSITY;
          MA_DQ_CALIB_PATTERN_A:  rd_data <= CALIB_PATTERN_A;
          MA_DQ_CALIB_PATTERN_B:  rd_data <= CALIB_PATTERN_B;
          // Write-only or reserved: undefined data, store contents
          default:                rd_data <= mem_rdata; // R18
        endcase
      end
    end
  end

  // Cycles since the last reset command, for the completion bound
  logic [TMR_W:0] since_rst;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      since_rst <= '0;
    end
    else if (is_rst)
    begin
      since_rst <= '0;
    end
    else if (auto_init_pending && since_rst != '1)
    begin
      since_rst <= since_rst + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_dai_done_clear: assert property ( // R6
    (state == ST_PRE_CAL) |-> !auto_init_pending)
    else $error("pending bit set after auto-init end");
  a_init_bound: assert property ( // R7
    (auto_init_pending && state == ST_AUTO_INIT) |->
      since_rst < (TMR_W+1)'(AUTO_INIT_MAX_CYC))
    else $error("auto-init exceeds its maximum time");
  a_only_reads_pd: assert property ( // R4
    (state == ST_AUTO_INIT || state == ST_RST_WAIT) |-> !mem_wr)
    else $error("mode register write during restricted step");
  a_zq_wait_ready: assert property ( // R11
    $rose(dev_ready) |-> $past(state, 1) == ST_IMPEDANCE_CALIBRATION_COMMAND &&
      $past(timer, 1) == TMR_W'(INIT_IMPEDANCE_CAL_CYC - 1))
    else $error("ready before calibration time elapsed");
  a_reset_restart: assert property ( // R13
    is_rst |=> state == ST_RST_WAIT && auto_init_pending && !dev_ready)
    else $error("reset command did not restart sequence");
  a_hiz_cke_low: assert property ( // R16
    !cke_s |=> !dq_oe)
    else $error("drivers on while clock enable low");
  a_rsvd_zero: assert property ( // R17
    (rd_valid && rd_addr_q == MA_DEVICE_INFO_STATUS) |->
      rd_data[5] == 1'b0 && rd_data[2:1] == 2'b00)
    else $error("reserved status bits not zero");
  a_strobe_every_read: assert property ( // R18
    acc_mrr |-> ##2 (rd_valid && dqs_strobe != $past(dqs_strobe, 1)))
    else $error("read answered without strobe toggle");
  a_ro_no_store: assert property ( // R19
    (acc_mrw && is_ro(cmd_s.addr)) |-> !mem_wr)
    else $error("write to read-only register stored");
  a_cal_trigger: assert property ( // R20
    cal_start |=> state == ST_IMPEDANCE_CALIBRATION_COMMAND ##[1:60] state == ST_READY)
    else $error("calibration code did not lead to ready");
  a_zq_result_latch: assert property ( // R21
    $rose(dev_ready) |-> zq_result == $past(zq_s, 1))
    else $error("self-test result not latched at completion");
endmodule : lp3i_init_seq

// ---- design/lp3i_pkg.sv ----
// Shared constants, command encodings and types for the init sequencer.
// Assumes a 40 MHz core clock and commands already decoded from the CA pins.
// Operation
// R1: Controller holds termination input static through init.
// R2: Reset command only after 200 us idle.
// R3: Only no-operations for 1 us after reset.
// R4: After wait, only reads and power-down accepted.
// R5: Reads only when bus untrained; training after init.
// R6: Auto-init pending bit: one busy, zero done.
// R7: Auto-init finishes within 10 us of reset.
// R8: Controller waits maximum or polls pending bit.
// R9: Training sends reset/no-op, then calibration write.
// R10: Calibration commands of shared devices never overlap.
// R11: Ready only 1 us after calibration command.
// R12: Controller writes latency, drive configuration before traffic.
// R13: Reset command anytime restarts at reset step.
// R14: Clock enable low 100 ns; 5 clocks first.
// R15: Boot read clock period 18 to 100 ns.
// R16: Outputs high impedance while clock enable low.
// R17: Reserved bits written zero, read as zero.
// R18: Read of write-only register still toggles strobe.
// R19: Writes to read-only registers change nothing.
// R20: 8-bit address; 3Fh resets, 0Ah calibrates.
// R21: Self-test result latched on calibration completion.
// R22: Latency support flags in bits 6, 7.
// R23: Controller issues no-operations during post-enable idle.
// R24: Calibration code FFh; reserved codes ignored.
// R25: Controller rounds waits up to whole cycles.
package lp3i_pkg;

  localparam int CLK_PERIOD_NS          = 25;
  localparam int POST_RESET_IDLE_NS     = 1000;
  localparam int AUTO_INIT_MAX_NS       = 10000;
  localparam int INIT_IMPEDANCE_CAL_NS  = 1000;
  // Least times round up, longest times round down
  localparam int POST_RESET_IDLE_CYC    =
    (POST_RESET_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AUTO_INIT_MAX_CYC      = AUTO_INIT_MAX_NS / CLK_PERIOD_NS;
  localparam int INIT_IMPEDANCE_CAL_CYC =
    (INIT_IMPEDANCE_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W                  = 10;

  // Mode register addresses
  localparam logic [7:0] MA_DEVICE_INFO_STATUS   = 8'h00;
  localparam logic [7:0] MA_BURST_WRITE_RECOVERY = 8'h01;
  localparam logic [7:0] MA_LATENCY_CFG          = 8'h02;
  localparam logic [7:0] MA_OUTPUT_DRIVE_CFG     = 8'h03;
  localparam logic [7:0] MA_REFRESH_RATE_STATUS  = 8'h04;
  localparam logic [7:0] MA_MAKER_CODE           = 8'h05;
  localparam logic [7:0] MA_REVISION_CODE_ONE    = 8'h06;
  localparam logic [7:0] MA_REVISION_CODE_TWO    = 8'h07;
  localparam logic [7:0] MA_WIDTH_DENSITY_TYPE   = 8'h08;
  localparam logic [7:0] MA_VENDOR_TEST_MODE     = 8'h09;
  localparam logic [7:0] MA_IMPEDANCE_CAL_CMD    = 8'h0A;
  localparam logic [7:0] MA_TERMINATION_CFG      = 8'h0B;
  localparam logic [7:0] MA_PARTIAL_BANK_MASK    = 8'h10;
  localparam logic [7:0] MA_PARTIAL_SEGMENT_MASK = 8'h11;
  localparam logic [7:0] MA_DQ_CALIB_PATTERN_A   = 8'h20;
  localparam logic [7:0] MA_DQ_CALIB_PATTERN_B   = 8'h28;
  localparam logic [7:0] MA_CA_TRAINING_ONE      = 8'h29;
  localparam logic [7:0] MA_CA_TRAINING_TWO      = 8'h2A;
  localparam logic [7:0] MA_CA_TRAINING_THREE    = 8'h30;
  localparam logic [7:0] MA_DEVICE_RESET_TRIGGER = 8'h3F;

  // Calibration code that starts the initial calibration
  localparam logic [7:0] CAL_CODE_INIT = 8'hFF;
  // Self-test code before any calibration completes
  localparam logic [1:0] ZQ_RESULT_RESET = 2'h0;
  localparam logic [7:0] RD_DATA_RESET   = 8'h00;

  // Decoded command opcodes
  localparam logic [2:0] CMD_NOP  = 3'h0;
  localparam logic [2:0] CMD_MRW  = 3'h1;
  localparam logic [2:0] CMD_MRR  = 3'h2;
  localparam logic [2:0] CMD_PDE  = 3'h3;
  localparam logic [2:0] CMD_PDX  = 3'h4;
  localparam logic [2:0] CMD_PREA = 3'h5;

  typedef struct packed {
    logic       valid;
    logic [2:0] op;
    logic [7:0] addr;
    logic [7:0] data;
  } lp3i_cmd_t;

  typedef enum logic [6:0] {
    ST_OFF       = 7'h01,
    ST_CKE_IDLE  = 7'h02,
    ST_RST_WAIT  = 7'h04,
    ST_AUTO_INIT = 7'h08,
    ST_PRE_CAL   = 7'h10,
    ST_IMPEDANCE_CALIBRATION_COMMAND    = 7'h20,
    ST_READY     = 7'h40
  } lp3i_state_t;

  // Read-only mode registers
  function automatic logic is_ro(input logic [7:0] a);
    case (a)
      MA_DEVICE_INFO_STATUS, MA_REFRESH_RATE_STATUS, MA_MAKER_CODE,
      MA_REVISION_CODE_ONE, MA_REVISION_CODE_TWO, MA_WIDTH_DENSITY_TYPE,
      MA_DQ_CALIB_PATTERN_A, MA_DQ_CALIB_PATTERN_B: is_ro = 1'b1;
      default: is_ro = 1'b0;
    endcase
  endfunction : is_ro

  // Write-only mode registers kept in the configuration store
  function automatic logic is_wo(input logic [7:0] a);
    case (a)
      MA_BURST_WRITE_RECOVERY, MA_LATENCY_CFG, MA_OUTPUT_DRIVE_CFG,
      MA_VENDOR_TEST_MODE, MA_IMPEDANCE_CAL_CMD, MA_TERMINATION_CFG,
      MA_PARTIAL_BANK_MASK, MA_PARTIAL_SEGMENT_MASK, MA_CA_TRAINING_ONE,
      MA_CA_TRAINING_TWO, MA_CA_TRAINING_THREE: is_wo = 1'b1;
      default: is_wo = 1'b0;
    endcase
  endfunction : is_wo

endpackage : lp3i_pkg

// ---- design/lp3i_sync.sv ----
// Two-stage synchroniser for pin inputs.
// Assumes each bit is a slow level or a pulse of at least one clock.
`timescale 1ns/1ps
module lp3i_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : lp3i_sync

// ---- testbench/lp3i_ctrl_model.sv ----
// Controller-side model driving clock enable and decoded command pins.
// Assumes the bench calls its tasks from one process; pins change at falling edges.
`timescale 1ns/1ps
module lp3i_ctrl_model
  import lp3i_pkg::*;
#(
  parameter int CKE_IDLE_CYC = 8000
) (
  input  wire logic           clk,
  output logic                cke_pin,
  output lp3i_pkg::lp3i_cmd_t cmd_pin
);
  // Supply ramp state: clock enable low, bus idle
  initial
  begin
    cke_pin = 1'b0;
    cmd_pin = '0;
  end

  // One command for exactly one cycle; released fields turn over
  task automatic send(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cmd_pin = '{valid: 1'b1, op: op, addr: a, data: d};
    @(negedge clk);
    cmd_pin = '{valid: 1'b0, op: ~op, addr: ~a, data: ~d}; // No stale value lingers
  endtask : send

  // Level change of clock enable at a falling edge
  task automatic set_cke(input logic v);
    @(negedge clk);
    cke_pin = v;
  endtask : set_cke

  // Low time after ramp plus stable clocks, then idle with no-operations
  task automatic power_up();
    cke_pin = 1'b0;
    repeat (4 + 5) @(negedge clk);
    cke_pin = 1'b1;
    repeat (CKE_IDLE_CYC) @(negedge clk);
  endtask : power_up
endmodule : lp3i_ctrl_model

// ---- testbench/tb.sv ----
// Self-checking bench for the init sequencer and its mode register map.
// Assumes the controller model in its own file; checks sampled at falling edges.
`timescale 1ns/1ps
module tb;
  import lp3i_pkg::*;
  localparam int         AI_CYC = 20;
  localparam logic [7:0] MAKER  = 8'h5A; // Arbitrary value
  localparam logic [7:0] REV1   = 8'h3C; // Arbitrary value
  localparam logic [7:0] REV2   = 8'h69; // Arbitrary value
  localparam logic [7:0] RO_ADR [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28};
  localparam logic [7:0] RO_EXP [7] = '{8'h03, MAKER, REV1, REV2, 8'h1F, 8'h55, 8'h33};
  localparam logic [7:0] WO_ADR [3] = '{8'h01, 8'h02, 8'h03};
  localparam logic [7:0] WO_MSK [3] = '{8'hE7, 8'hDF, 8'h0F}; // Reserved bits kept zero

  logic       clk      = 1'b0;
  logic       resetn   = 1'b0;
  logic [1:0] zq_strap = 2'h0;
  logic       cke_pin;
  lp3i_cmd_t  cmd_pin;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       dqs_strobe;
  logic       dq_oe;
  logic       dev_ready;
  logic       auto_init_pending;
  logic       cmd_refused;
  logic [7:0] v;
  logic [7:0] wv [3];
  int         bad_count  = 0;
  int         num_checks = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  lp3i_ctrl_model u_ctrl (
    .clk     (clk),
    .cke_pin (cke_pin),
    .cmd_pin (cmd_pin)
  );

  lp3i_init_seq #(
    .AUTO_INIT_CYC  (AI_CYC),
    .RL3_SUPPORT    (1'b1),
    .ALT_WL_SUPPORT (1'b0),
    .REFRESH_RATE   (3'h3),
    .MAKER_ID       (MAKER),
    .REVISION_ONE   (REV1),
    .REVISION_TWO   (REV2)
  ) u_dut (
    .clk               (clk),
    .resetn            (resetn),
    .cke_pin           (cke_pin),
    .cmd_pin           (cmd_pin),
    .zq_strap          (zq_strap),
    .rd_data           (rd_data),
    .rd_valid          (rd_valid),
    .dqs_strobe        (dqs_strobe),
    .dq_oe             (dq_oe),
    .dev_ready         (dev_ready),
    .auto_init_pending (auto_init_pending),
    .cmd_refused       (cmd_refused)
  );

  // Expected status register from pending state and self-test code
  function automatic logic [7:0] exp_status(input logic pend, input logic [1:0] zq);
    return {1'b1, 1'b0, 1'b0, zq, 2'b00, pend};
  endfunction : exp_status

  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk_data

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk_flag

  // Read one register; the strobe must toggle even where data is undefined
  task automatic mrr(input logic [7:0] a, output logic [7:0] d);
    logic old;
    int   n;
    old = dqs_strobe;
    u_ctrl.send(CMD_MRR, a, 8'h00);
    for (n = 0; n < 8 && rd_valid !== 1'b1; n++) @(negedge clk);
    chk_flag(rd_valid, 1'b1);
    d = rd_data;
    chk_flag(dqs_strobe, ~old);
  endtask : mrr

  // Send a command and watch whether it is refused
  task automatic try_cmd(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d,
                         input logic exp);
    logic seen;
    seen = 1'b0;
    u_ctrl.send(op, a, d);
    repeat (5)
    begin
      @(negedge clk);
      seen |= (cmd_refused === 1'b1);
    end
    chk_flag(seen, exp);
  endtask : try_cmd

  // Reset command through calibration; the same path serves a re-entry
  task automatic init_seq();
    logic [1:0] zq;
    logic [7:0] code;
    zq       = 2'($urandom);
    code     = 8'($urandom);
    code     = (code == CAL_CODE_INIT) ? 8'h00 : code;
    zq_strap = zq;
    u_ctrl.send(CMD_MRW, MA_DEVICE_RESET_TRIGGER, 8'h00);
    repeat (3) @(negedge clk);
    chk_flag(dev_ready, 1'b0);
    try_cmd(CMD_MRR, MA_DEVICE_INFO_STATUS, 8'h00, 1'b1);
    repeat (30) @(negedge clk);
    mrr(MA_DEVICE_INFO_STATUS, v);
    chk_data(v, exp_status(1'b1, ZQ_RESULT_RESET));
    try_cmd(CMD_MRW, MA_BURST_WRITE_RECOVERY, 8'h00, 1'b1);
    repeat (12) @(negedge clk);
    mrr(MA_DEVICE_INFO_STATUS, v);
    chk_data(v, exp_status(1'b0, ZQ_RESULT_RESET));
    chk_flag(auto_init_pending, 1'b0);
    u_ctrl.send(CMD_MRW, MA_IMPEDANCE_CAL_CMD, code);
    repeat (50) @(negedge clk);
    chk_flag(dev_ready, 1'b0);
    u_ctrl.send(CMD_MRW, MA_IMPEDANCE_CAL_CMD, CAL_CODE_INIT);
    repeat (38) @(negedge clk);
    chk_flag(dev_ready, 1'b0);
    repeat (6) @(negedge clk);
    chk_flag(dev_ready, 1'b1);
    mrr(MA_DEVICE_INFO_STATUS, v);
    chk_data(v, exp_status(1'b0, zq));
  endtask : init_seq

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    void'($urandom(38304));
    repeat (4) @(negedge clk);
    chk_data(rd_data, RD_DATA_RESET);
    chk_flag(auto_init_pending, 1'b1);
    chk_flag(dq_oe, 1'b0);
    resetn = 1'b1;
    u_ctrl.power_up();
    chk_flag(dq_oe, 1'b1);
    try_cmd(CMD_MRR, MA_DEVICE_INFO_STATUS, 8'h00, 1'b1);
    try_cmd(CMD_PREA, 8'h00, 8'h00, 1'b0);
    init_seq();
    // Configuration writes for the target frequency, then read back
    for (int i = 0; i < 3; i++)
    begin
      wv[i] = 8'($urandom) & WO_MSK[i];
      u_ctrl.send(CMD_MRW, WO_ADR[i], wv[i]);
    end
    for (int i = 0; i < 3; i++)
    begin
      mrr(WO_ADR[i], v);
      chk_data(v, wv[i]);
    end
    // Writes to read-only places change nothing
    u_ctrl.send(CMD_MRW, MA_MAKER_CODE, 8'hFF);
    u_ctrl.send(CMD_MRW, MA_DEVICE_INFO_STATUS, 8'h01);
    mrr(MA_DEVICE_INFO_STATUS, v);
    chk_flag(v[0], 1'b0);
    for (int i = 0; i < 7; i++)
    begin
      mrr(RO_ADR[i], v);
      chk_data(v, RO_EXP[i]);
    end
    mrr(8'h40, v);
    // Power-down entry and exit
    try_cmd(CMD_PDE, 8'h00, 8'h00, 1'b0);
    chk_flag(dq_oe, 1'b0);
    try_cmd(CMD_PDX, 8'h00, 8'h00, 1'b0);
    chk_flag(dq_oe, 1'b1);
    // Clock enable low: drivers off, commands ignored without refusal
    u_ctrl.set_cke(1'b0);
    repeat (4) @(negedge clk);
    chk_flag(dq_oe, 1'b0);
    try_cmd(CMD_MRR, MA_DEVICE_INFO_STATUS, 8'h00, 1'b0);
    u_ctrl.set_cke(1'b1);
    repeat (6) @(negedge clk);
    init_seq();
    print_verdict();
  end

  // Watchdog well beyond the expected run of about 8500 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule : tb
